/* common/gmc_map.vh */
// monitor-channel engine: slot positions, opcodes and message codes
// assumes one channel of 32 bits, monitor byte msb first, a then e last
`ifndef GMC_MAP_VH
`define GMC_MAP_VH

// bit positions inside the selected channel
`define GMC_POS_MON_FIRST 5'd16
`define GMC_POS_MON_LAST  5'd23
`define GMC_POS_A         5'd30
`define GMC_POS_E         5'd31

// frame counts for repeats, acknowledge holding and end marking
`define GMC_MIN_FRAMES    2'd2

// released level of an open-drain slot
`define GMC_FLOAT         1'b1
`define GMC_IDLE_BYTE     8'hff

// command opcodes in the upper nibble of the first byte
`define GMC_OP_BYTE_WR    4'h0
`define GMC_OP_BYTE_RD    4'h1
`define GMC_OP_NIB_WR     4'h2
`define GMC_OP_NIB_RD     4'h3
`define GMC_OP_EOC_IND    4'h4
`define GMC_OP_EOC_RD     4'h5
`define GMC_OP_EOC_WR     4'h6
`define GMC_NIB_ADDR_MAX  4'h5

// identification, response and indication codes
`define GMC_DEVID_B1      8'h01
`define GMC_DEVID_B2      8'h00
`define GMC_RESP_DEVID_B1 8'h80
`define GMC_IND_M56_B1    8'h00
`define GMC_IND_M4_B1     8'h20

// register port selectors
`define GMC_SEL_BYTE      2'd0
`define GMC_SEL_NIB       2'd1
`define GMC_SEL_EOC       2'd2

`endif

/* logic/gmc_sync.v */
// two-flop synchroniser for the tdm pins and channel straps
// assumes inputs are asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none

module gmc_sync (
    input  wire       clk_in,
    input  wire       reset_n_in,
    input  wire [5:0] d_in,
    output reg  [5:0] q_out
);

    reg [5:0] meta;

    // ****
    // synchroniser pair
    // ****
    // first stage is read by the second stage only
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta  <= 6'h3f;
            q_out <= 6'h3f;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end

endmodule // gmc_sync

`default_nettype wire

/* logic/gmc_slot.v */
// slot timer: finds bit clock edges, tracks position inside the frame
// assumes synchronised bit clock (two clocks per bit) and frame sync
`timescale 1ns/1ps
`default_nettype none

module gmc_slot (
    input  wire       clk_in,
    input  wire       reset_n_in,
    input  wire       dcl_in,
    input  wire       fsc_in,
    input  wire [2:0] sel_in,
    output reg        tx_stb_out,
    output reg        rx_stb_out,
    output reg  [4:0] pos_out,
    output reg        mine_out
);

    reg        dcl_d;
    reg        fsc_d;
    reg  [9:0] half;
    wire       fsc_rise = fsc_in && !fsc_d;
    // frame sync and the first bit clock rise of a frame share one edge
    wire [9:0] half_inc = (fsc_rise ? 10'h3ff : half) + 10'h001;

    // ****
    // half-bit counter
    // ****
    // even half-bit starts a bit (drive), odd half-bit is mid-bit (sample)
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dcl_d      <= 1'b1; // matches the synchroniser's reset level
            fsc_d      <= 1'b1;
            half       <= 10'h3ff;
            tx_stb_out <= 1'b0;
            rx_stb_out <= 1'b0;
            pos_out    <= 5'h00;
            mine_out   <= 1'b0;
        end else begin
            dcl_d      <= dcl_in;
            fsc_d      <= fsc_in;
            tx_stb_out <= 1'b0;
            rx_stb_out <= 1'b0;
            if (dcl_in && !dcl_d) begin
                half       <= half_inc;
                tx_stb_out <= !half_inc[0];
                rx_stb_out <= half_inc[0];
                pos_out    <= half_inc[5:1];
                mine_out   <= (half_inc[8:6] == sel_in) && !half_inc[9]; // RULE23
            end else if (fsc_rise) begin
                half <= 10'h3ff;             // next clock edge is half-bit 0
            end
        end
    end

endmodule // gmc_slot

`default_nettype wire

/* logic/gmc_engine.v */
// monitor-channel engine: handshake, command decode, responses, indications
// assumes register file and maintenance deframer outside, on clk_in
// Function
// RULE1 - every message is one or two bytes, each byte sent in two frames at least
// RULE2 - a and e slots float when unused; active means pulled low
// RULE3 - e flags a new byte; a from the far side acknowledges it
// RULE4 - idle after two frames with a and e inactive; data slot all ones
// RULE5 - start only after two idle frames; e low with the first byte
// RULE6 - repeat each byte two frames at least and until acknowledged
// RULE7 - after first ack, e floats for first frame of byte two
// RULE8 - receiver holds a low two frames to confirm the first byte
// RULE9 - a floats on first instance of a later byte, low on the second
// RULE10 - on mismatching repeats, a stays low until two equal bytes arrive
// RULE11 - message ends with e high for two frames
// RULE12 - maintenance register updates raise indication messages
// RULE13 - reads answered with a response; writes done silently
// RULE14 - all messages acknowledged; invalid ones cause no action
// RULE15 - opcode in upper first-byte nibble; identification and nop codes
// RULE16 - byte commands: 4-bit address, data in second byte
// RULE17 - nibble commands: address 0 to 5, data in upper second nibble
// RULE18 - read commands are one byte; the answer is two bytes
// RULE19 - response opcodes for byte, nibble, eoc read and identification
// RULE20 - eoc word: first address bit is msb, last info bit is lsb
// RULE21 - queued indications go out before a read response
// RULE22 - controller decodes first byte of every message it receives
// RULE23 - drive and sample only in the selected channel
// RULE24 - indication first bytes for m5/m6, m4 and eoc; data in second
// RULE25 - sending an indication clears its pending flag
// RULE26 - byte confirmed on two equal frames; write after whole message
// RULE27 - one whole message at a time, queued, never interleaved
`timescale 1ns/1ps
`default_nettype none
`include "gmc_map.vh"

module gmc_engine (
    input  wire        clk_in,
    input  wire        reset_n_in,
    input  wire        dcl_in,
    input  wire        fsc_in,
    input  wire        din_in,
    input  wire [2:0]  channel_select_in,
    output reg         dout_out,
    output reg         dout_oe_n_out,
    output reg         reg_wr_out,
    output reg         reg_rd_out,
    output reg  [1:0]  reg_sel_out,
    output reg  [3:0]  reg_addr_out,
    output reg  [11:0] reg_wdata_out,
    input  wire [11:0] reg_rdata_in,
    input  wire        m4_upd_in,
    input  wire [7:0]  m4_data_in,
    input  wire        m56_upd_in,
    input  wire [7:0]  m56_data_in,
    input  wire        eoc_upd_in,
    input  wire [11:0] eoc_data_in,
    output reg  [2:0]  ind_clr_out
);

    localparam [1:0] T_IDLE = 2'd0;
    localparam [1:0] T_B1   = 2'd1;
    localparam [1:0] T_B2   = 2'd2;
    localparam [1:0] T_END  = 2'd3;

    // saturating frame counter step
    function [1:0] sat_inc;
        input [1:0] v;
        begin
            sat_inc = (v == 2'd3) ? v : v + 2'd1;
        end
    endfunction

    wire [5:0] pin_q;
    wire       tx_stb;
    wire       rx_stb;
    wire [4:0] pos;
    wire       mine;
    wire       din_s = pin_q[2];
    wire       in_mon = (pos >= `GMC_POS_MON_FIRST) && (pos <= `GMC_POS_MON_LAST);

    reg [7:0]  rx_sh;
    reg        rx_a;
    reg        rx_e;
    reg        fr_done;
    reg        r_act;
    reg        r_eprev;
    reg        r_conf;
    reg [1:0]  r_cnt;
    reg [1:0]  a_cnt;
    reg [7:0]  r_cand;
    reg [7:0]  m_b1;
    reg [7:0]  m_b2;
    reg        cmd_go;
    reg        tx_a;
    reg        tx_e;
    reg [7:0]  tx_byte;
    reg [1:0]  t_st;
    reg [1:0]  t_cnt;
    reg        t_af;
    reg [1:0]  idle_cnt;
    reg [7:0]  t_b2;
    reg        p_m56;
    reg        p_m4;
    reg        p_eoc;
    reg [7:0]  d_m56;
    reg [7:0]  d_m4;
    reg [11:0] d_eoc;
    reg        resp_pend;
    reg [7:0]  resp_b1;
    reg [7:0]  resp_b2;
    reg        rd_wait;
    reg [2:0]  next_clr;
    reg [7:0]  next_b1;
    reg [7:0]  next_b2;
    reg        next_resp_take;
    reg        have_msg;

    wire [3:0] op     = m_b1[7:4];
    wire       nib_ok = (m_b1[3:0] <= `GMC_NIB_ADDR_MAX); // RULE17
    // writes need both bytes, reads one; refused commands raise no strobe and leave the address
    wire       wr_ok  = (r_cnt == 2'd2) && (op == `GMC_OP_BYTE_WR || op == `GMC_OP_EOC_WR
                        || (op == `GMC_OP_NIB_WR && nib_ok)); // RULE13
    wire       rd_ok  = (r_cnt == 2'd1) && (op == `GMC_OP_BYTE_RD || (op == `GMC_OP_NIB_RD
                        && nib_ok) || (op == `GMC_OP_EOC_RD && m_b1[3:0] == 4'h0)); // RULE18

    gmc_sync u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .d_in       ({channel_select_in, din_in, fsc_in, dcl_in}),
        .q_out      (pin_q)
    );

    gmc_slot u_slot (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .dcl_in     (pin_q[0]),
        .fsc_in     (pin_q[1]),
        .sel_in     (pin_q[5:3]),
        .tx_stb_out (tx_stb),
        .rx_stb_out (rx_stb),
        .pos_out    (pos),
        .mine_out   (mine)
    );

    // ****
    // pin sampling and driving
    // ****
    // other channels are ignored on input and released on output
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_sh         <= `GMC_IDLE_BYTE;
            rx_a          <= `GMC_FLOAT;
            rx_e          <= `GMC_FLOAT;
            fr_done       <= 1'b0;
            dout_out      <= `GMC_FLOAT;
            dout_oe_n_out <= 1'b1;
        end else begin
            fr_done <= rx_stb && mine && (pos == `GMC_POS_E);
            if (rx_stb && mine) begin // RULE23
                if (in_mon) rx_sh <= {rx_sh[6:0], din_s};
                if (pos == `GMC_POS_A) rx_a <= din_s;
                if (pos == `GMC_POS_E) rx_e <= din_s;
            end
            if (tx_stb) begin
                // only zeros are driven, ones are left to the pull-up
                if (mine && ((in_mon && !tx_byte[~pos[2:0]]) || (pos == `GMC_POS_A && !tx_a)
                        || (pos == `GMC_POS_E && !tx_e))) begin
                    dout_out      <= 1'b0; // RULE2
                    dout_oe_n_out <= 1'b0;
                end else begin
                    dout_out      <= `GMC_FLOAT;
                    dout_oe_n_out <= 1'b1; // RULE23
                end
            end
        end
    end

    // ****
    // receive handshake
    // ****
    // decisions are taken once per frame, after the e slot was sampled
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r_act   <= 1'b0;
            r_eprev <= `GMC_FLOAT;
            r_conf  <= 1'b0;
            r_cnt   <= 2'd0;
            a_cnt   <= 2'd0;
            r_cand  <= `GMC_IDLE_BYTE;
            m_b1    <= `GMC_IDLE_BYTE;
            m_b2    <= `GMC_IDLE_BYTE;
            cmd_go  <= 1'b0;
            tx_a    <= `GMC_FLOAT;
        end else begin
            cmd_go <= 1'b0;
            if (fr_done) begin
                r_eprev <= rx_e;
                if (!r_act) begin
                    tx_a <= `GMC_FLOAT;
                    if (!rx_e) begin // RULE3
                        r_act  <= 1'b1;
                        r_cand <= rx_sh;
                        r_conf <= 1'b0;
                        r_cnt  <= 2'd0;
                    end
                end else if (rx_e && r_eprev) begin
                    r_act  <= 1'b0; // RULE11
                    tx_a   <= `GMC_FLOAT;
                    cmd_go <= 1'b1; // RULE26
                end else if (rx_e) begin
                    // first instance of the next byte, or first end frame
                    r_cand <= rx_sh;
                    r_conf <= 1'b0;
                    tx_a   <= (r_cnt == 2'd1 && a_cnt < `GMC_MIN_FRAMES) ? 1'b0 : 1'b1; // RULE8
                end else if (!r_conf && rx_sh == r_cand) begin
                    r_conf <= 1'b1; // RULE26
                    tx_a   <= 1'b0; // RULE9
                    a_cnt  <= 2'd1;
                    r_cnt  <= sat_inc(r_cnt);
                    if (r_cnt == 2'd0) m_b1 <= rx_sh;
                    if (r_cnt == 2'd1) m_b2 <= rx_sh;
                end else if (rx_sh != r_cand) begin
                    r_cand <= rx_sh;
                    r_conf <= 1'b0;
                    tx_a   <= 1'b0; // RULE10
                end else begin
                    tx_a  <= 1'b0; // RULE8
                    a_cnt <= sat_inc(a_cnt);
                end
            end
        end
    end

    // ****
    // command decode and register access
    // ****
    // every message is acknowledged above; unknown ones end here unused
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_wr_out    <= 1'b0;
            reg_rd_out    <= 1'b0;
            reg_sel_out   <= `GMC_SEL_BYTE;
            reg_addr_out  <= 4'h0;
            reg_wdata_out <= 12'h000;
            rd_wait       <= 1'b0;
            resp_pend     <= 1'b0;
            resp_b1       <= `GMC_IDLE_BYTE;
            resp_b2       <= `GMC_IDLE_BYTE;
        end else begin
            reg_wr_out <= 1'b0;
            reg_rd_out <= 1'b0;
            rd_wait    <= reg_rd_out;
            if (next_resp_take) resp_pend <= 1'b0;
            if (cmd_go) begin
                if (r_cnt == 2'd2 && m_b1 == `GMC_DEVID_B1 && m_b2 == `GMC_DEVID_B2) begin
                    resp_pend <= 1'b1; // RULE19
                    resp_b1   <= `GMC_RESP_DEVID_B1;
                    resp_b2   <= 8'h00;
                end else begin
                    reg_wr_out <= wr_ok; // RULE13
                    reg_rd_out <= rd_ok; // RULE18
                    if (wr_ok || rd_ok) reg_addr_out <= m_b1[3:0]; // RULE16
                    case (m_b1[7:4]) // RULE15
                        `GMC_OP_BYTE_WR: begin
                            reg_sel_out   <= `GMC_SEL_BYTE;
                            reg_wdata_out <= {4'h0, m_b2};
                        end
                        `GMC_OP_NIB_WR: begin
                            reg_sel_out   <= `GMC_SEL_NIB;
                            reg_wdata_out <= {8'h00, m_b2[7:4]}; // RULE17
                        end
                        `GMC_OP_EOC_WR: begin
                            reg_sel_out   <= `GMC_SEL_EOC;
                            reg_wdata_out <= {m_b1[3:0], m_b2}; // RULE20
                        end
                        `GMC_OP_BYTE_RD: begin
                            reg_sel_out <= `GMC_SEL_BYTE;
                        end
                        `GMC_OP_NIB_RD: begin
                            reg_sel_out <= `GMC_SEL_NIB;
                        end
                        `GMC_OP_EOC_RD: begin
                            reg_sel_out <= `GMC_SEL_EOC;
                        end
                        default: begin
                            reg_sel_out <= reg_sel_out; // RULE14
                        end
                    endcase
                end
            end
            // read data is valid the cycle after the read strobe
            if (rd_wait) begin
                resp_pend <= 1'b1; // RULE13
                case (reg_sel_out) // RULE19
                    `GMC_SEL_BYTE: begin
                        resp_b1 <= {`GMC_OP_BYTE_RD, reg_addr_out};
                        resp_b2 <= reg_rdata_in[7:0];
                    end
                    `GMC_SEL_NIB: begin
                        resp_b1 <= {`GMC_OP_NIB_RD, reg_addr_out};
                        resp_b2 <= {reg_rdata_in[3:0], 4'h0};
                    end
                    default: begin
                        resp_b1 <= {`GMC_OP_EOC_RD, reg_rdata_in[11:8]}; // RULE20
                        resp_b2 <= reg_rdata_in[7:0];
                    end
                endcase
            end
        end
    end

    // ****
    // indication queue
    // ****
    // a new update in the clearing cycle wins, so no change is lost
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            p_m56       <= 1'b0;
            p_m4        <= 1'b0;
            p_eoc       <= 1'b0;
            d_m56       <= 8'h00;
            d_m4        <= 8'h00;
            d_eoc       <= 12'h000;
            ind_clr_out <= 3'h0;
        end else begin
            ind_clr_out <= next_clr; // RULE25
            p_m56 <= m56_upd_in || (p_m56 && !next_clr[0]); // RULE12
            p_m4  <= m4_upd_in || (p_m4 && !next_clr[1]);
            p_eoc <= eoc_upd_in || (p_eoc && !next_clr[2]);
            if (m56_upd_in) d_m56 <= m56_data_in;
            if (m4_upd_in) d_m4 <= m4_data_in;
            if (eoc_upd_in) d_eoc <= eoc_data_in;
        end
    end

    // next message to load, indications ahead of any read response
    always @* begin
        next_clr       = 3'h0;
        next_b1        = `GMC_IDLE_BYTE;
        next_b2        = `GMC_IDLE_BYTE;
        next_resp_take = 1'b0;
        have_msg       = p_m56 || p_m4 || p_eoc || resp_pend;
        if (fr_done && t_st == T_IDLE && rx_a && rx_e && idle_cnt != 2'd0) begin // RULE5
            if (p_m56) begin
                next_clr[0] = 1'b1;
                next_b1     = `GMC_IND_M56_B1; // RULE24
                next_b2     = d_m56;
            end else if (p_m4) begin
                next_clr[1] = 1'b1;
                next_b1     = `GMC_IND_M4_B1;
                next_b2     = d_m4;
            end else if (p_eoc) begin
                next_clr[2] = 1'b1;
                next_b1     = {`GMC_OP_EOC_IND, d_eoc[11:8]};
                next_b2     = d_eoc[7:0];
            end else if (resp_pend) begin
                next_resp_take = 1'b1; // RULE21
                next_b1        = resp_b1;
                next_b2        = resp_b2;
            end
        end
    end

    // ****
    // transmit handshake
    // ****
    // one message is held until its end marker, so bytes never interleave
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            t_st     <= T_IDLE;
            t_cnt    <= 2'd0;
            t_af     <= 1'b0;
            idle_cnt <= 2'd0;
            t_b2     <= `GMC_IDLE_BYTE;
            tx_byte  <= `GMC_IDLE_BYTE;
            tx_e     <= `GMC_FLOAT;
        end else if (fr_done) begin
            idle_cnt <= (rx_a && rx_e) ? sat_inc(idle_cnt) : 2'd0; // RULE4
            t_cnt    <= sat_inc(t_cnt);
            case (t_st)
                T_IDLE: begin
                    tx_byte <= `GMC_IDLE_BYTE; // RULE4
                    tx_e    <= `GMC_FLOAT;
                    if (have_msg && rx_a && rx_e && idle_cnt != 2'd0) begin
                        t_st    <= T_B1; // RULE27
                        tx_byte <= next_b1;
                        t_b2    <= next_b2;
                        tx_e    <= 1'b0; // RULE5
                        t_cnt   <= 2'd1;
                    end
                end
                T_B1: begin
                    if (t_cnt >= `GMC_MIN_FRAMES && !rx_a) begin // RULE6
                        t_st    <= T_B2;
                        tx_byte <= t_b2;
                        tx_e    <= `GMC_FLOAT; // RULE7
                        t_cnt   <= 2'd1;
                        t_af    <= 1'b0;
                    end
                end
                T_B2: begin
                    tx_e <= 1'b0; // RULE7
                    if (rx_a) t_af <= 1'b1;
                    if (t_cnt >= `GMC_MIN_FRAMES && t_af && !rx_a) begin // RULE1
                        t_st    <= T_END;
                        tx_byte <= `GMC_IDLE_BYTE;
                        tx_e    <= `GMC_FLOAT; // RULE11
                        t_cnt   <= 2'd1;
                    end
                end
                default: begin
                    if (t_cnt >= `GMC_MIN_FRAMES) t_st <= T_IDLE; // RULE11
                end
            endcase
        end
    end

endmodule // gmc_engine

`default_nettype wire

/* verification/gmc_engine_properties.sv */
// port checker for the monitor-channel engine
// assumes bind onto gmc_engine, one clock domain
`timescale 1ns/1ps
`default_nettype none
module gmc_engine_properties (
    input wire logic       clk_in,
    input wire logic       reset_n_in,
    input wire logic       dout_out,
    input wire logic       dout_oe_n_out,
    input wire logic       reg_wr_out,
    input wire logic       reg_rd_out,
    input wire logic [1:0] reg_sel_out,
    input wire logic [3:0] reg_addr_out,
    input wire logic [2:0] ind_clr_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // strobes are single pulses
    a_wr_one_cycle: assert property (reg_wr_out |=> !reg_wr_out)
        else $error("write strobe long");
    a_rd_one_cycle: assert property (reg_rd_out |=> !reg_rd_out)
        else $error("read strobe long");
    a_one_command: assert property (!(reg_wr_out && reg_rd_out))
        else $error("read and write together");
    a_sel_legal: assert property (reg_wr_out || reg_rd_out |-> reg_sel_out != 2'd3)
        else $error("bad selector");
    a_nib_addr_max: assert property (reg_wr_out && reg_sel_out == 2'd1 |-> reg_addr_out <= 4'h5)
        else $error("nibble address high");
    a_addr_with_strobe: assert property ($changed(reg_addr_out) |-> reg_wr_out || reg_rd_out)
        else $error("address moved alone");
    a_clear_pulse: assert property (ind_clr_out != 3'h0 |-> $onehot(ind_clr_out) ##1 ind_clr_out == 3'h0)
        else $error("clear not single");
    // released pin reads high; a driven bit stands at least 8 clocks
    a_release_high: assert property (dout_oe_n_out |-> dout_out)
        else $error("released pin low");
    a_bit_stands: assert property ($fell(dout_oe_n_out) |-> !dout_oe_n_out [*8])
        else $error("driven bit short");
    c_write: cover property (reg_wr_out);
    c_read: cover property (reg_rd_out);
    c_clear: cover property (ind_clr_out != 3'h0);
endmodule // gmc_engine_properties
`default_nettype wire

/* verification/gmc_peer.sv */
// controller model: free bit clock, frame sync, one 32-bit channel a frame
// assumes the engine sits on channel 0 and the line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module gmc_peer (
    input  wire logic [7:0] byte_in,
    input  wire logic       e_in,
    input  wire logic       a_in,
    input  wire logic       dout_in,
    input  wire logic       dout_oe_n_in,
    output logic            dcl_out,
    output logic            fsc_out,
    output logic            din_out,
    output logic [7:0]      byte_out,
    output logic            a_out,
    output logic            e_out,
    output int              frames_out,
    output int              stray_out
);
    logic [7:0] shift;
    wire        line = dout_oe_n_in | dout_in; // pull-up when released
    // drive on first clock rise of a bit, sample on the second
    initial begin
        {dcl_out, fsc_out, frames_out, stray_out} = '0;
        {din_out, byte_out, a_out, e_out} = 11'h7ff;
        forever for (int b = 0; b < 32; b++) begin
            #40 dcl_out = 1'b1;
            fsc_out = (b == 0);
            din_out = (b > 15 && b < 24) ? byte_in[23 - b] : b == 30 ? a_in : b == 31 ? e_in : 1'b1;
            #40 dcl_out = 1'b0;
            #40 dcl_out = 1'b1;
            shift = {shift[6:0], line};
            if (!dout_oe_n_in && (b < 16 || (b > 23 && b < 30))) stray_out++;
            if (b == 23) byte_out = shift;
            if (b == 30) a_out = line;
            if (b == 31) e_out = line;
            if (b == 31) frames_out++;
            #40 dcl_out = 1'b0;
        end
    end
endmodule // gmc_peer
`default_nettype wire

/* verification/gmc_engine_bench.sv */
// bench for gmc_engine with the controller model on the far side
// assumes channel 0 and a register file answering with a set word
`timescale 1ns/1ps
`default_nettype none
module gmc_engine_bench;
    logic        clk_in = 1'b0, reset_n_in = 1'b0, double_rate_bit_clock, frame_sync_pulse, din, dout, oe_n, wr, rd;
    logic        m4_upd = 1'b0, m56_upd = 1'b0, tx_e = 1'b1, tx_a = 1'b1, rx_a, rx_e;
    logic [1:0]  sel;
    logic [3:0]  addr;
    logic [11:0] wdata, rdata = 12'h0a5;
    logic [7:0]  tx_b = 8'hff, rx_b, b1, b2;
    logic [2:0]  clr, clr_log = 3'h0;
    logic [17:0] wlog;
    int          fails = 0, checked = 0, cycles = 0, frames, stray, wr_n = 0, acks;
    gmc_engine gmc_engine_inst (.clk_in, .reset_n_in, .dcl_in(double_rate_bit_clock), .fsc_in(frame_sync_pulse), .din_in(din),
        .channel_select_in(3'h0), .dout_out(dout), .dout_oe_n_out(oe_n), .reg_wr_out(wr),
        .reg_rd_out(rd), .reg_sel_out(sel), .reg_addr_out(addr), .reg_wdata_out(wdata),
        .reg_rdata_in(rdata), .m4_upd_in(m4_upd), .m4_data_in(8'h3c), .m56_upd_in(m56_upd),
        .m56_data_in(8'hc3), .eoc_upd_in(1'b0), .eoc_data_in(12'h000), .ind_clr_out(clr));
    gmc_peer gmc_peer_inst (.byte_in(tx_b), .e_in(tx_e), .a_in(tx_a), .dout_in(dout),
        .dout_oe_n_in(oe_n), .dcl_out(double_rate_bit_clock), .fsc_out(frame_sync_pulse), .din_out(din), .byte_out(rx_b),
        .a_out(rx_a), .e_out(rx_e), .frames_out(frames), .stray_out(stray));
    always #5 clk_in = ~clk_in;
    // log strobes off the launch edge; cut a hang
    always @(negedge clk_in) begin
        cycles++;
        if (wr) wr_n++;
        if (wr) wlog = {sel, addr, wdata};
        clr_log = clr_log | clr;
        if (cycles == 90000) fails++;
        if (cycles == 90000) finish_test();
    end
    task automatic check(input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one frame: set what we offer, wait for the frame end
    task automatic xfer(input logic [7:0] b, input logic e);
        int f = frames;
        tx_b = b;
        tx_e = e;
        wait (frames != f);
    endtask
    // bytes repeated until acked, then e high and idle
    task automatic send_msg(input logic [7:0] m1, m2, input bit two);
        acks = 0;
        for (int n = 0; n < 2 || (rx_a && n < 12); n++) xfer(m1, 1'b0);
        acks += !rx_a;
        if (two) xfer(m2, 1'b1);
        for (int n = 0; two && (n < 2 || (rx_a && n < 12)); n++) xfer(m2, 1'b0);
        acks += two && !rx_a;
        repeat (4) xfer(8'hff, 1'b1);
    endtask
    // receive one device message, acking as a controller does
    task automatic get_msg;
        logic [7:0] last = 'x;
        int ph = 0;
        {b1, b2} = 'x;
        for (int n = 0; n < 60 && ph < 5; n++) begin
            xfer(8'hff, 1'b1);
            if (ph == 0 && !rx_e && rx_b === last) b1 = rx_b;
            if (ph == 2 && !rx_e && rx_b === last) b2 = rx_b;
            ph += (ph[0] == 0 && ph < 3 && !rx_e && rx_b === last) || (ph == 1 && rx_b !== b1)
                || (ph > 2 && rx_e);
            tx_a = !(ph == 1 || ph == 3);
            last = rx_b;
        end
        repeat (2) xfer(8'hff, 1'b1);
    endtask
    task automatic t_idle;
        repeat (3) xfer(8'hff, 1'b1);
        check({rx_b, rx_a, rx_e}, 10'h3ff);
    endtask
    task automatic t_write;
        send_msg(8'h03, 8'h5a, 1'b1);
        check(acks, 2);
        check(wlog, {2'd0, 4'h3, 12'h05a});
        send_msg(8'h26, 8'h90, 1'b1);
        check({acks, wr_n}, {32'd2, 32'd1});
        send_msg(8'h25, 8'h9f, 1'b1);
        check(wlog, {2'd1, 4'h5, 12'h009});
        t_idle();
    endtask
    task automatic t_read;
        send_msg(8'h13, 8'hff, 1'b0);
        get_msg();
        check({b1, b2}, 16'h13a5);
        send_msg(8'h01, 8'h00, 1'b1);
        get_msg();
        check({b1, b2}, 16'h8000);
    endtask
    // updates land while a read is arriving: indications first
    task automatic t_ind;
        fork
            send_msg(8'h13, 8'hff, 1'b0);
            begin
                repeat (300) @(posedge clk_in);
                #1 {m4_upd, m56_upd} = 2'b11;
                @(posedge clk_in) #1 {m4_upd, m56_upd} = 2'b00;
            end
        join
        get_msg();
        check({b1, b2}, 16'h00c3);
        get_msg();
        check({b1, b2}, 16'h203c);
        get_msg();
        check({b1, b2, clr_log}, {16'h13a5, 3'h3});
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        #1 reset_n_in = 1'b1;
        t_idle();
        t_write();
        t_read();
        t_ind();
        check(stray, 0);
        finish_test();
    end
endmodule // gmc_engine_bench
bind gmc_engine gmc_engine_properties gmc_engine_properties_inst (.clk_in, .reset_n_in,
    .dout_out, .dout_oe_n_out, .reg_wr_out, .reg_rd_out, .reg_sel_out, .reg_addr_out,
    .ind_clr_out);
`default_nettype wire
